/* pkg/pcasp_defines.svh */
// Constants for the area 6 card status and paging block
// Assumes a 32-bit Avalon-MM register bus with byte offsets
`ifndef PCASP_DEFINES_SVH
`define PCASP_DEFINES_SVH
`define PCASP_ADDR_W        4
`define PCASP_OFF_GCR       4'h0
`define PCASP_OFF_STATUS    4'h4
`define PCASP_OFF_IRQ_STAT  4'h8
`define PCASP_OFF_IRQ_MASK  4'hc
`define PCASP_OFF_CSC       4'h1
`define PCASP_GCR_RESET_B   0
`define PCASP_GCR_PAGE_LO_B 1
`define PCASP_GCR_PAGE_HI_B 2
`define PCASP_GCR_IOTYPE_B  3
`define PCASP_GCR_MASK      8'h0f
`define PCASP_GCR_RST_VAL   8'h00
`define PCASP_ST_RDY_B      7
`define PCASP_ST_WP_B       6
`define PCASP_ST_B2_B       1
`define PCASP_ST_B1_B       0
`define PCASP_IRQ_W         4
`define PCASP_SPACE_ATTR    2'h0
`define PCASP_SPACE_IO      2'h1
`define PCASP_SPACE_COMMON  2'h2
`endif

/* pkg/pcasp_pkg.sv */
// Types for the area 6 card status and paging block
// Assumes pcasp_defines.svh is on the include path
package pcasp_pkg;
    typedef logic [1:0] pcasp_space_t;
    typedef enum logic [1:0] {
        PCASP_IDLE,
        PCASP_ANSWER
    } pcasp_bus_state_t;
endpackage

/* rtl/pcasp_core.sv */
// Area 6 card status, address paging and status change events
// Assumes inputs synchronous to ref_clk and an Avalon-MM master
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
`include "pcasp_defines.svh"

// Notes on behaviour
// - Paging bits act only on common memory, never attribute or I/O space.
// - 16-Mbyte mode drives card A25/A24 from control bits 2 and 1.
// - After reset the high paging bit, driving A25, reads zero.
// - Status bit 7 shows ready/busy for memory cards, IREQ for I/O cards.
// - Status bit 6 shows write protect for memory cards, zero for I/O.
// - Status bits 1 and 0 show BVD2/BVD1 or speaker/status-changed.
module pcasp_core #(
    parameter int ADDR_W = `PCASP_ADDR_W
) (
    input  wire logic                ref_clk,
    input  wire logic                srst,
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic                card_access,
    input  wire pcasp_pkg::pcasp_space_t card_space,
    input  wire logic [25:24]        cpu_addr_hi,
    input  wire logic                pin_ready,
    input  wire logic                pin_write_protect,
    input  wire logic                pin_bvd2_spkr,
    input  wire logic                pin_bvd1_stschg,
    input  wire logic                pin_cd1,
    input  wire logic                pin_cd2,
    output logic                     card_addr_page_hi,
    output logic                     card_addr_page_lo,
    output logic                     space_select_out,
    output logic                     card_reset_out,
    output logic                     irq
);
    import pcasp_pkg::*;

    // Refuse an address bus too narrow for the register map
    if (ADDR_W < 4) begin : g_bad_addr_w
        $error("ADDR_W must be at least 4");
    end

    logic [7:0]               gcr;
    logic [7:0]               area6_card_status;
    logic [`PCASP_IRQ_W-1:0]  card_status_change_reg;
    logic [`PCASP_IRQ_W-1:0]  irq_mask;
    logic [`PCASP_IRQ_W-1:0]  pins_q;
    pcasp_bus_state_t         bus_state;

    wire io_type   = gcr[`PCASP_GCR_IOTYPE_B];
    wire is_common = (card_space == `PCASP_SPACE_COMMON);
    wire sel_gcr   = (avs_address == ADDR_W'(`PCASP_OFF_GCR));
    wire sel_st    = (avs_address == ADDR_W'(`PCASP_OFF_STATUS));
    wire sel_is    = (avs_address == ADDR_W'(`PCASP_OFF_IRQ_STAT));
    wire sel_im    = (avs_address == ADDR_W'(`PCASP_OFF_IRQ_MASK));
    wire bus_req   = avs_read | avs_write;
    wire take      = bus_req && (bus_state == PCASP_IDLE);
    // Writes land at the edge that completes the transfer
    wire commit    = bus_req && (bus_state == PCASP_ANSWER);
    wire wr_lo     = commit && avs_write && avs_byteenable[0];

    // Status view per card interface type
    wire [7:0] next_status = {
        pin_ready,
        io_type ? 1'b0 : pin_write_protect,
        4'h0,
        pin_bvd2_spkr,
        pin_bvd1_stschg
    };

    wire [`PCASP_IRQ_W-1:0] pins_now =
        {pin_cd2, pin_cd1, pin_bvd1_stschg, pin_ready};
    wire [`PCASP_IRQ_W-1:0] evt = pins_now ^ pins_q;
    wire [`PCASP_IRQ_W-1:0] w1c =
        (wr_lo && sel_is) ? avs_writedata[`PCASP_IRQ_W-1:0]
                          : {`PCASP_IRQ_W{1'b0}};

    wire [31:0] rd_mux =
        sel_gcr ? {24'h0, gcr} :
        sel_st  ? {24'h0, area6_card_status} :
        sel_is  ? {28'h0, card_status_change_reg} :
        sel_im  ? {28'h0, irq_mask} : 32'h0;

    // Paging applies to common memory only
    wire next_hi = (card_access && is_common) ?
                   gcr[`PCASP_GCR_PAGE_HI_B] : cpu_addr_hi[25];
    wire next_lo = (card_access && is_common) ?
                   gcr[`PCASP_GCR_PAGE_LO_B] : cpu_addr_hi[24];

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            gcr <= `PCASP_GCR_RST_VAL;
        end else if (wr_lo && sel_gcr) begin
            gcr <= avs_writedata[7:0] & `PCASP_GCR_MASK;
        end
    end

    // Set wins over write-one-to-clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            card_status_change_reg <= '0;
            irq_mask               <= '0;
            // Seeded from the pins so reset brings no false edge
            pins_q                 <= pins_now;
        end else begin
            pins_q <= pins_now;
            card_status_change_reg <= (card_status_change_reg & ~w1c) | evt;
            if (wr_lo && sel_im) begin
                irq_mask <= avs_writedata[`PCASP_IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            area6_card_status <= 8'h00;
            card_addr_page_hi <= 1'b0;
            card_addr_page_lo <= 1'b0;
            space_select_out  <= 1'b0;
            card_reset_out    <= 1'b0;
            irq               <= 1'b0;
        end else begin
            area6_card_status <= next_status;
            card_addr_page_hi <= next_hi;
            card_addr_page_lo <= next_lo;
            space_select_out  <= card_access && is_common;
            card_reset_out    <= gcr[`PCASP_GCR_RESET_B];
            irq <= |(card_status_change_reg & irq_mask);
        end
    end

    // Each request answered in the cycle after it is taken
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bus_state       <= PCASP_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else begin
            case (bus_state)
                PCASP_IDLE: begin
                    if (bus_req) begin
                        bus_state       <= PCASP_ANSWER;
                        avs_waitrequest <= 1'b0;
                        avs_readdata    <= avs_read ? rd_mux : 32'h0;
                    end
                end
                PCASP_ANSWER: begin
                    bus_state       <= PCASP_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_state       <= PCASP_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    property p_page_common;
        @(posedge ref_clk) disable iff (srst)
        (card_access && is_common) |=>
            card_addr_page_hi == $past(gcr[`PCASP_GCR_PAGE_HI_B]);
    endproperty
    a_page_common: assert property (p_page_common)
        else $error("A25 page bit not driven from control bit 2");

    property p_page_other;
        @(posedge ref_clk) disable iff (srst)
        (card_access && !is_common) |=>
            {card_addr_page_hi, card_addr_page_lo} == $past(cpu_addr_hi);
    endproperty
    a_page_other: assert property (p_page_other)
        else $error("Paging affected non-common access");

    property p_hi_reset;
        @(posedge ref_clk) $fell(srst) |-> !gcr[`PCASP_GCR_PAGE_HI_B];
    endproperty
    a_hi_reset: assert property (p_hi_reset)
        else $error("High paging bit not zero after reset");

    property p_rdy;
        @(posedge ref_clk) disable iff (srst)
        1 |=> area6_card_status[`PCASP_ST_RDY_B] == $past(pin_ready);
    endproperty
    a_rdy: assert property (p_rdy)
        else $error("Status bit 7 does not follow ready pin");

    property p_wp_io;
        @(posedge ref_clk) disable iff (srst)
        io_type ##1 io_type |-> !area6_card_status[`PCASP_ST_WP_B];
    endproperty
    a_wp_io: assert property (p_wp_io)
        else $error("Status bit 6 nonzero for I/O card");

    property p_bvd;
        @(posedge ref_clk) disable iff (srst)
        1 |=> area6_card_status[1:0] ==
              $past({pin_bvd2_spkr, pin_bvd1_stschg});
    endproperty
    a_bvd: assert property (p_bvd)
        else $error("Status bits 1..0 do not follow pins");

    property p_space;
        @(posedge ref_clk) disable iff (srst)
        (card_access && is_common) |=> space_select_out;
    endproperty
    a_space: assert property (p_space)
        else $error("Space output low for common memory");

    property p_space_low;
        @(posedge ref_clk) disable iff (srst)
        !(card_access && is_common) |=> !space_select_out;
    endproperty
    a_space_low: assert property (p_space_low)
        else $error("Space output high outside common memory");

    property p_card_reset;
        @(posedge ref_clk) disable iff (srst)
        1 |=> card_reset_out == $past(gcr[`PCASP_GCR_RESET_B]);
    endproperty
    a_card_reset: assert property (p_card_reset)
        else $error("Card reset output does not follow control bit");

    property p_answer;
        @(posedge ref_clk) disable iff (srst)
        take |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer)
        else $error("Bus answer not one cycle after request");

    c_io_read: cover property (@(posedge ref_clk) disable iff (srst)
        io_type && take && avs_read && sel_st);
    c_page: cover property (@(posedge ref_clk) disable iff (srst)
        card_access && is_common && card_addr_page_hi);
    c_irq: cover property (@(posedge ref_clk) disable iff (srst)
        $rose(irq));
endmodule

/* test/pcasp_card_model.sv */
// Removable card model driving the area 6 status pins
// Assumes the bench picks pin levels and the card interface type
`timescale 1ns/1ns
module pcasp_card_model (
    input  wire logic       ref_clk,
    input  wire logic       io_card,
    input  wire logic       in_reset,
    input  wire logic [4:0] lvl,
    output logic            pin_ready,
    output logic            pin_write_protect,
    output logic            pin_bvd2_spkr,
    output logic            pin_bvd1_stschg,
    output logic            pin_cd1,
    output logic            pin_cd2
);
    logic wp_noise;
    initial wp_noise = 1'b0;
    // Write protect is meaningless on an I/O card, so it toggles
    always @(posedge ref_clk) begin
        wp_noise <= ~wp_noise;
    end
    // Card reports busy while it is held in reset
    assign pin_ready         = lvl[0] & ~in_reset;
    assign pin_write_protect = io_card ? wp_noise : lvl[1];
    assign pin_bvd2_spkr     = lvl[2];
    assign pin_bvd1_stschg   = lvl[3];
    assign pin_cd1           = lvl[4];
    assign pin_cd2           = lvl[4];
endmodule

/* test/tb.sv */
// Self-checking bench for the area 6 status and paging block
// Assumes the card model and the design files are compiled first
`timescale 1ns/1ns
`include "pcasp_defines.svh"
module tb;
    import pcasp_pkg::*;
    logic         ref_clk = 1'b0;
    logic         srst = 1'b1;
    logic [3:0]   avs_address = 4'h0;
    logic         avs_read = 1'b0;
    logic         avs_write = 1'b0;
    logic [31:0]  avs_writedata = 32'h0;
    logic [31:0]  avs_readdata;
    logic         avs_waitrequest;
    logic         card_access = 1'b0;
    pcasp_space_t card_space = `PCASP_SPACE_ATTR;
    logic [1:0]   cpu_addr_hi = 2'h0;
    logic         io_card = 1'b0;
    logic [4:0]   lvl = 5'h1f;
    logic         rdy, wp, b2, b1, cd1, cd2, pg_hi, pg_lo, sp_sel, c_rst, irq;
    logic [31:0]  q;
    integer       fail_count = 0, checks = 0, seed = 3926, gcr, exp_st;
    pcasp_card_model u_card (.ref_clk(ref_clk), .io_card(io_card),
        .in_reset(c_rst), .lvl(lvl), .pin_ready(rdy), .pin_write_protect(wp),
        .pin_bvd2_spkr(b2), .pin_bvd1_stschg(b1), .pin_cd1(cd1),
        .pin_cd2(cd2));
    pcasp_core u_dut (.ref_clk(ref_clk), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .card_access(card_access),
        .card_space(card_space), .cpu_addr_hi(cpu_addr_hi), .pin_ready(rdy),
        .pin_write_protect(wp), .pin_bvd2_spkr(b2), .pin_bvd1_stschg(b1),
        .pin_cd1(cd1), .pin_cd2(cd2), .card_addr_page_hi(pg_hi),
        .card_addr_page_lo(pg_lo), .space_select_out(sp_sel),
        .card_reset_out(c_rst), .irq(irq));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic tick(input integer k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    // One bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input integer d);
        integer n;
        @(posedge ref_clk);
        avs_read <= ~w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n == 20) begin
            fail_count++;
            give_verdict();
        end
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        tick(1);
        chk(pg_hi, 1'b0);
        bus(0, `PCASP_OFF_GCR, 0);
        chk(q[7:0], 8'h00);
        card_access <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            for (int s = 0; s < 3; s++) begin
                gcr = p << 1;
                bus(1, `PCASP_OFF_GCR, gcr);
                card_space <= s[1:0];
                cpu_addr_hi <= 2'($random(seed));
                tick(3);
                chk({pg_hi, pg_lo}, s == 2 ? p : cpu_addr_hi);
                chk(sp_sel, s == 2);
            end
        end
        // Mid-run reset with the high page bit set
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        tick(1);
        chk({pg_hi, pg_lo}, 2'h0);
        for (int i = 0; i < 8; i++) begin
            gcr = i[0] * 8 + i[1];
            bus(1, `PCASP_OFF_GCR, gcr);
            io_card <= i[0];
            lvl <= {1'b1, 4'($random(seed))};
            bus(1, `PCASP_OFF_STATUS, 32'hff);
            bus(1, `PCASP_OFF_IRQ_STAT, 32'hf);
            bus(0, `PCASP_OFF_STATUS, 0);
            exp_st = (lvl[0] & ~i[1]) * 128 + (lvl[1] & ~i[0]) * 64;
            chk(q[7:0], exp_st + lvl[2] * 2 + lvl[3]);
            chk(c_rst, i[1]);
            bus(0, `PCASP_OFF_IRQ_STAT, 0);
            chk(q[3:0], 4'h0);
        end
        bus(1, `PCASP_OFF_IRQ_MASK, 32'hf);
        tick(2);
        chk(irq, 1'b0);
        @(posedge ref_clk);
        lvl[3] <= ~lvl[3];
        tick(3);
        chk(irq, 1'b1);
        bus(0, `PCASP_OFF_IRQ_STAT, 0);
        chk(q[3:0], 4'h2);
        bus(1, `PCASP_OFF_IRQ_STAT, 32'h2);
        tick(3);
        chk(irq, 1'b0);
        bus(1, `PCASP_OFF_IRQ_MASK, 0);
        lvl[3] <= ~lvl[3];
        tick(3);
        chk(irq, 1'b0);
        bus(0, `PCASP_OFF_IRQ_STAT, 0);
        chk(q[3:0], 4'h2);
        bus(0, 4'h2, 0);
        chk(q, 32'h0);
        give_verdict();
    end
endmodule
